// ===== src/pma_pkg.sv
/*
 * shared constants and carrier types for the program memory addressing block.
 * assumes one 20 MHz clock, synchronous active-high reset, avalon-mm register access.
 */
package pma_pkg;

  // ************************************************************
  // register map (byte addresses, one aligned word each)
  // ************************************************************
  localparam logic [3:0] OFS_TABLE_PAGE = 4'h0;
  localparam logic [3:0] OFS_DATA_READ_PAGE = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int TBL_PAGE_W = 8;
  localparam int DSR_PAGE_W = 10;
  localparam int PC_W = 23;
  localparam int STAT_TRAP_BIT = 31;
  localparam int STAT_SEL_BIT = 30;
  localparam logic [7:0] TBL_PAGE_RST = 8'h00;
  localparam logic [9:0] DSR_PAGE_RST = 10'h001;
  localparam logic [9:0] DSR_PAGE_TRAP = 10'h000;
  localparam logic [9:0] DSR_PS_MIN = 10'h200;
  localparam logic [15:0] VIS_BOUNDARY = 16'h8000;
  localparam logic [1:0] PS_LOW_WORD = 2'h2;
  localparam logic [1:0] PS_HIGH_BYTE = 2'h3;
  // reset vectors: plain values, picked by the target-vector select strap
  localparam logic [22:0] RST_VEC_PRIMARY = 23'h000000;
  localparam logic [22:0] RST_VEC_AUX = 23'h000200;
  // start of the auxiliary flash region (word-address space)
  localparam logic [23:0] AUX_BASE = 24'h7FC000;
  localparam logic [1:0] BOOT_WAIT = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic high;        // upper (msb) space instead of lsw space
    logic byte_mode;   // byte access, bit 0 of the offset picks the byte
    logic [15:0] ea;   // working register value / effective address
  } pma_req_type;

  typedef struct packed {
    logic valid;       // one-cycle result strobe
    logic trap;        // address error trap
    logic data_space;  // access belongs to data space, not program space
    logic [15:0] data;
  } pma_ans_type;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_TABLE,
    SRC_VIS,
    SRC_FETCH
  } pma_src_type;

endpackage

// ===== src/pma_program_memory_addressing.sv
/*
 * program memory address generation: program counter, table reads and
 * program space visibility through the paged data window, plus the two
 * page registers on an avalon-mm slave.
 * assumes a program memory that returns prog_rdata combinationally, in the same
 * cycle as prog_addr_q, and flash busy levels per region from the flash
 * controller on the same clock.
 */
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

// Contract
// - 4M x 24-bit program address space
// - pc advances two per instruction word
// - pc bit 0 zero for fetches
// - table address is page over working register
// - table page spans 32K words
// - table offset wraps inside page
// - low read lsw, high read upper word
// - two side-by-side 16-bit table spaces
// - phantom byte accepted without fault
// - table page 8-bit, cleared, upper zero
// - read page 10-bit, upper bits zero
// - read page resets to one
// - read page zero traps window reads
// - program space needs page at threshold
// - window maps any 32-Kbyte segment
// - fetch other region while one busy
// - reset vector chosen by select bit
// - high read returns zero top byte
// - low word ignores bit 0, byte uses it
// - window address from page and ea
// - page top bits pick lsw or msb
module pma_program_memory_addressing
(
  input wire logic clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  // reset-target-vector select strap (pin)
  input wire logic reset_target_vector_select,
  // instruction fetch
  input wire logic fetch_req,
  input wire logic fetch_jump,
  input wire logic [22:0] fetch_target,
  output logic fetch_ready,
  output logic fetch_valid,
  output logic [23:0] fetch_word,
  output logic [22:0] pc,
  // table read
  input wire logic table_read_req,
  input wire pma_pkg::pma_req_type table_read_cmd,
  output logic table_read_ready,
  // paged data window read
  input wire logic vis_req,
  input wire pma_pkg::pma_req_type vis_cmd,
  output logic vis_ready,
  // answers for table and window reads
  output pma_pkg::pma_ans_type rd_ans,
  // program memory side
  output logic [23:0] prog_addr_q,
  output logic prog_rd_q,
  input wire logic [23:0] prog_rdata,
  input wire logic user_flash_busy,
  input wire logic aux_flash_busy
);

  // ************************************************************
  // helpers
  // ************************************************************

  // lane/space selection shared by table and window reads
  function automatic logic [15:0] pick_data(input logic [23:0] w, input logic high,
                                            input logic byte_mode, input logic sel);
    logic [15:0] r;
    r = 16'h0000;
    if (!high && !byte_mode)
      r = w[15:0];
    else if (!high)
      r = sel ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    else if (!byte_mode || !sel)
      r = {8'h00, w[23:16]};
    else
      r = 16'h0000;
    return r;
  endfunction

  // region of a program address: aux flash or user flash
  function automatic logic is_aux(input logic [23:0] a);
    return a >= pma_pkg::AUX_BASE;
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] tbl_page_q;
  logic [9:0] dsr_page_q;
  logic trap_seen_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic sel_meta_q;
  logic sel_sync_q;
  logic [1:0] boot_cnt_q;
  logic boot_done_q;
  logic [22:0] pc_q;
  pma_pkg::pma_src_type src_q;
  pma_pkg::pma_req_type cmd_q;
  logic cmd_high_q;
  logic [15:0] ans_data_q;
  logic ans_valid_q;
  logic ans_trap_q;
  logic ans_ds_q;
  logic fetch_valid_q;
  logic [23:0] fetch_word_q;

  logic bus_req;
  logic wr_fire;
  logic [1:0] reg_idx;
  logic vis_prog;
  logic vis_trap;
  logic fetch_region_busy;
  logic take_table;
  logic take_vis;
  logic take_fetch;

  // ************************************************************
  // avalon slave: one wait state on every access
  // ************************************************************
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign wr_fire = avs_write & ack_q;
  assign reg_idx = avs_address[3:2];
  assign avs_readdata = rdata_q;
  assign avs_response = resp_q;

  // handshake: ack on the second cycle of a held request
  always_ff @(posedge clk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= bus_req & ~ack_q;
  end

  // read data and response prepared before the ack edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
      resp_q <= pma_pkg::RESP_OKAY;
    end
    else if (bus_req && !ack_q)
    begin
      rdata_q <= 32'h0000_0000;
      resp_q <= pma_pkg::RESP_OKAY;
      case (avs_address)
        pma_pkg::OFS_TABLE_PAGE:
          rdata_q <= {24'h000000, tbl_page_q};
        pma_pkg::OFS_DATA_READ_PAGE:
          rdata_q <= {22'h000000, dsr_page_q};
        pma_pkg::OFS_STATUS:
          rdata_q <= {trap_seen_q, sel_sync_q, 7'h00, pc_q};
        default:
          resp_q <= pma_pkg::RESP_SLVERR;
      endcase
    end
  end

  // table page: only the low byte lane has storage
  always_ff @(posedge clk)
  begin
    if (rst)
      tbl_page_q <= pma_pkg::TBL_PAGE_RST;
    else if (wr_fire && avs_address == pma_pkg::OFS_TABLE_PAGE && avs_byteenable[0])
      tbl_page_q <= avs_writedata[7:0];
  end

  // data read page: bits 15..10 dropped on write
  always_ff @(posedge clk)
  begin
    if (rst)
      dsr_page_q <= pma_pkg::DSR_PAGE_RST;
    else if (wr_fire && avs_address == pma_pkg::OFS_DATA_READ_PAGE)
    begin
      if (avs_byteenable[0])
        dsr_page_q[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1])
        dsr_page_q[9:8] <= avs_writedata[9:8];
    end
  end

  // sticky trap flag, write one to clear; a new trap wins over the clear
  always_ff @(posedge clk)
  begin
    if (rst)
      trap_seen_q <= 1'b0;
    else if (take_vis && vis_trap)
      trap_seen_q <= 1'b1;
    else if (wr_fire && avs_address == pma_pkg::OFS_STATUS && avs_byteenable[3]
             && avs_writedata[pma_pkg::STAT_TRAP_BIT])
      trap_seen_q <= 1'b0;
  end

  // ************************************************************
  // reset vector strap and program counter
  // ************************************************************

  // strap comes from a pin, so two flops before use
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_meta_q <= 1'b0;
      sel_sync_q <= 1'b0;
    end
    else
    begin
      sel_meta_q <= reset_target_vector_select;
      sel_sync_q <= sel_meta_q;
    end
  end

  // wait for the synchroniser to settle before loading the vector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      boot_cnt_q <= 2'h0;
      boot_done_q <= 1'b0;
    end
    else if (!boot_done_q)
    begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
      boot_done_q <= (boot_cnt_q == pma_pkg::BOOT_WAIT);
    end
  end

  // pc: bit 0 forced low, word index in bits 22..1
  always_ff @(posedge clk)
  begin
    if (rst)
      pc_q <= 23'h000000;
    else if (!boot_done_q && boot_cnt_q == pma_pkg::BOOT_WAIT)
      pc_q <= sel_sync_q ? pma_pkg::RST_VEC_AUX : pma_pkg::RST_VEC_PRIMARY;
    else if (fetch_jump && boot_done_q)
      pc_q <= {fetch_target[22:1], 1'b0};
    else if (take_fetch)
      pc_q <= {pc_q[22:1] + 22'h000001, 1'b0};
  end
  assign pc = pc_q;

  // ************************************************************
  // request arbitration: table, then window, then fetch
  // ************************************************************

  // window decode: below the boundary is plain data space for any nonzero read page
  assign vis_prog = vis_cmd.ea >= pma_pkg::VIS_BOUNDARY
                    && dsr_page_q >= pma_pkg::DSR_PS_MIN;
  assign vis_trap = dsr_page_q == pma_pkg::DSR_PAGE_TRAP;

  // only the region being erased stalls fetches from it
  assign fetch_region_busy = is_aux({1'b0, pc_q}) ? aux_flash_busy
                                                   : user_flash_busy;

  assign table_read_ready = 1'b1;
  assign vis_ready = ~table_read_req;
  assign fetch_ready = boot_done_q & ~fetch_jump & ~table_read_req & ~vis_req
                       & ~fetch_region_busy;
  assign take_table = table_read_req;
  assign take_vis = vis_req & ~table_read_req;
  assign take_fetch = fetch_req & fetch_ready;

  // memory address register: one access per cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prog_addr_q <= 24'h000000;
      prog_rd_q <= 1'b0;
      src_q <= pma_pkg::SRC_NONE;
      cmd_q <= '0;
      cmd_high_q <= 1'b0;
    end
    else
    begin
      prog_rd_q <= 1'b0;
      src_q <= pma_pkg::SRC_NONE;
      if (take_table)
      begin
        // 16-bit offset field is closed: no carry into the page
        prog_addr_q <= {tbl_page_q, table_read_cmd.ea};
        prog_rd_q <= 1'b1;
        src_q <= pma_pkg::SRC_TABLE;
        cmd_q <= table_read_cmd;
        cmd_high_q <= table_read_cmd.high;
      end
      else if (take_vis)
      begin
        prog_addr_q <= {1'b0, dsr_page_q[7:0], vis_cmd.ea[14:0]};
        prog_rd_q <= vis_prog && !vis_trap;
        src_q <= pma_pkg::SRC_VIS;
        cmd_q <= vis_cmd;
        cmd_high_q <= dsr_page_q[9:8] == pma_pkg::PS_HIGH_BYTE;
      end
      else if (take_fetch)
      begin
        prog_addr_q <= {1'b0, pc_q[22:1], 1'b0};
        prog_rd_q <= 1'b1;
        src_q <= pma_pkg::SRC_FETCH;
      end
    end
  end

  // trap and data-space marks travel with the window request
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ans_trap_q <= 1'b0;
      ans_ds_q <= 1'b0;
    end
    else
    begin
      ans_trap_q <= take_vis && vis_trap;
      ans_ds_q <= take_vis && !vis_trap && !vis_prog;
    end
  end

  // ************************************************************
  // answer formatting, one cycle after the memory read
  // ************************************************************
  logic trap_d1_q;
  logic ds_d1_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ans_valid_q <= 1'b0;
      ans_data_q <= 16'h0000;
      trap_d1_q <= 1'b0;
      ds_d1_q <= 1'b0;
      fetch_valid_q <= 1'b0;
      fetch_word_q <= 24'h000000;
    end
    else
    begin
      ans_valid_q <= src_q == pma_pkg::SRC_TABLE || src_q == pma_pkg::SRC_VIS;
      trap_d1_q <= ans_trap_q;
      ds_d1_q <= ans_ds_q;
      ans_data_q <= 16'h0000;
      if (prog_rd_q && src_q != pma_pkg::SRC_FETCH)
        ans_data_q <= pick_data(prog_rdata, cmd_high_q, cmd_q.byte_mode, cmd_q.ea[0]);
      fetch_valid_q <= src_q == pma_pkg::SRC_FETCH;
      if (src_q == pma_pkg::SRC_FETCH)
        fetch_word_q <= prog_rdata;
    end
  end

  assign rd_ans = '{valid: ans_valid_q, trap: trap_d1_q, data_space: ds_d1_q,
                    data: ans_data_q};
  assign fetch_valid = fetch_valid_q;
  assign fetch_word = fetch_word_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_pc_even;
    @(posedge clk) disable iff (rst) pc_q[0] == 1'b0;
  endproperty
  a_pc_even: assert property (p_pc_even) else $error("pc bit 0 set");

  property p_pc_step;
    @(posedge clk) disable iff (rst)
      take_fetch && !fetch_jump ##1 boot_done_q |-> pc_q == $past(pc_q) + 23'h000002;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not advance by two");

  property p_tbl_addr;
    @(posedge clk) disable iff (rst)
      take_table |=> prog_addr_q == {$past(tbl_page_q), $past(table_read_cmd.ea)};
  endproperty
  a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");

  property p_trap;
    @(posedge clk) disable iff (rst)
      take_vis && dsr_page_q == 10'h000 |-> ##2 rd_ans.valid && rd_ans.trap;
  endproperty
  a_trap: assert property (p_trap) else $error("page zero did not trap");

  property p_no_ps_low_page;
    @(posedge clk) disable iff (rst)
      take_vis && dsr_page_q < 10'h200 |=> !prog_rd_q;
  endproperty
  a_no_ps_low_page: assert property (p_no_ps_low_page) else $error("low page hit ps");

  property p_dsr_reset;
    @(posedge clk) $fell(rst) |-> dsr_page_q == 10'h001;
  endproperty
  a_dsr_reset: assert property (p_dsr_reset) else $error("read page not one");

  property p_tbl_reset;
    @(posedge clk) $fell(rst) |-> tbl_page_q == 8'h00;
  endproperty
  a_tbl_reset: assert property (p_tbl_reset) else $error("table page not zero");

  property p_high_zero;
    @(posedge clk) disable iff (rst)
      take_table && table_read_cmd.high |-> ##2 rd_ans.data[15:8] == 8'h00;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("phantom byte nonzero");

  property p_vis_addr;
    @(posedge clk) disable iff (rst)
      take_vis |=> prog_addr_q[23] == 1'b0
                   && prog_addr_q[22:15] == $past(dsr_page_q[7:0]);
  endproperty
  a_vis_addr: assert property (p_vis_addr) else $error("window address wrong");

  property p_stall_region;
    @(posedge clk) disable iff (rst)
      take_fetch |-> !(is_aux({1'b0, pc_q}) ? aux_flash_busy : user_flash_busy);
  endproperty
  a_stall_region: assert property (p_stall_region) else $error("fetch from busy region");

  property p_bus_ack;
    @(posedge clk) disable iff (rst)
      bus_req && !ack_q |=> !avs_waitrequest;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("slave did not answer");

  c_table_high: cover property (@(posedge clk) disable iff (rst)
    take_table && table_read_cmd.high ##2 rd_ans.valid);
  c_vis_msb: cover property (@(posedge clk) disable iff (rst)
    take_vis && dsr_page_q[9:8] == 2'h3 && vis_cmd.ea[15]);
  c_fetch_aux_busy: cover property (@(posedge clk) disable iff (rst)
    take_fetch && aux_flash_busy);
  c_trap: cover property (@(posedge clk) disable iff (rst) take_vis && vis_trap);

endmodule // pma_program_memory_addressing

// ===== tb/pma_prog_mem_model.sv
/*
 * program memory model standing on the far side of the addressing block.
 * assumes read data are wanted in the same cycle as the registered address.
 */
`timescale 1ns/1ps
module pma_prog_mem_model
(
  input wire logic clk,
  input wire logic [23:0] prog_addr_q,
  input wire logic prog_rd_q,
  output logic [23:0] prog_rdata
);
  logic [23:0] last_q = 24'h5A5A5A;

  // each 24-bit word is derived from its word address; bit 0 only picks a byte
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[8:1] ^ 8'h96, a[16:1] ^ a[23:8]};
  endfunction

  // idle bus shows the inverse of the last value, so stale data never match
  always_ff @(posedge clk)
    last_q <= prog_rdata;
  assign prog_rdata = prog_rd_q ? word_at(prog_addr_q) : ~last_q;
endmodule // pma_prog_mem_model

// ===== tb/tb.sv
/*
 * self-checking bench for the program memory addressing block.
 * assumes the memory model answers reads and the bench plays cpu and bus master.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb;
  // ************************************************************
  // signals
  // ************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest, fetch_ready, fetch_valid, table_read_ready, vis_ready, prog_rd_q;
  logic reset_target_vector_select = 1'b0;
  logic fetch_req = 1'b0;
  logic fetch_jump = 1'b0;
  logic [22:0] fetch_target = 23'h0;
  logic [23:0] fetch_word, prog_addr_q, prog_rdata;
  logic [22:0] pc, exp_pc;
  logic table_read_req = 1'b0;
  logic vis_req = 1'b0;
  pma_pkg::pma_req_type table_read_cmd = 18'h00000;
  pma_pkg::pma_req_type vis_cmd = 18'h00000;
  pma_pkg::pma_ans_type rd_ans, cur;
  logic user_flash_busy = 1'b0;
  logic aux_flash_busy = 1'b0;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] seed = 32'hC8E6;
  logic [7:0] tpage = 8'h00;
  logic [9:0] rpage = 10'h001;
  logic [9:0] pl [7] = '{10'h000, 10'h001, 10'h1FF, 10'h200, 10'h2AB, 10'h300, 10'h3C5};
  pma_pkg::pma_ans_type aq [$];
  logic [23:0] fq [$];
  logic [23:0] fexp;

  always #25 clk = ~clk;

  pma_program_memory_addressing dut
  (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_response, .avs_waitrequest, .reset_target_vector_select,
    .fetch_req, .fetch_jump, .fetch_target, .fetch_ready, .fetch_valid, .fetch_word, .pc,
    .table_read_req, .table_read_cmd, .table_read_ready, .vis_req, .vis_cmd, .vis_ready,
    .rd_ans, .prog_addr_q, .prog_rd_q, .prog_rdata, .user_flash_busy, .aux_flash_busy
  );

  pma_prog_mem_model mem
  (
    .clk, .prog_addr_q, .prog_rd_q, .prog_rdata
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // bench's own copy of the memory contents
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[8:1] ^ 8'h96, a[16:1] ^ a[23:8]};
  endfunction

  // upper space has a phantom top byte that always reads zero
  function automatic logic [15:0] exp_data(input logic [23:0] w, input logic h,
                                           input logic bm, input logic sel);
    logic [15:0] wd;
    wd = h ? {8'h00, w[23:16]} : w[15:0];
    if (bm)
      return {8'h00, sel ? wd[15:8] : wd[7:0]};
    return wd;
  endfunction

  task automatic stop_test();
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // avalon master: holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= ~wr;
    avs_write <= wr;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      mismatches++;
      $display("ERROR waitrequest expected 0 seen %0h", avs_waitrequest);
      stop_test();
    end
    rd = avs_readdata;
    rs = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [31:0] ex, input logic [1:0] exr);
    logic [31:0] rd;
    logic [1:0] rs;
    bus(1'b0, a, 32'h0, 4'hF, rd, rs);
    `CHK("readdata", ex, rd)
    `CHK("response", exr, rs)
  endtask

  // the bench keeps its own copy of both pages, lane by lane
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] rd;
    logic [1:0] rs;
    bus(1'b1, a, d, be, rd, rs);
    if (a == pma_pkg::OFS_TABLE_PAGE && be[0])
      tpage = d[7:0];
    if (a == pma_pkg::OFS_DATA_READ_PAGE)
      rpage = {be[1] ? d[9:8] : rpage[9:8], be[0] ? d[7:0] : rpage[7:0]};
  endtask

  task automatic tbl_rd(input logic h, input logic bm, input logic [15:0] ea);
    @(posedge clk);
    table_read_req <= 1'b1;
    table_read_cmd <= {h, bm, ea};
    aq.push_back({3'b100, exp_data(word_at({tpage, ea}), h, bm, ea[0])});
  endtask

  // valid cleared in a note means only the trap flag is judged
  task automatic vis_rd(input logic bm, input logic [15:0] ea);
    pma_pkg::pma_ans_type e;
    @(posedge clk);
    vis_req <= 1'b1;
    vis_cmd <= {1'b0, bm, ea};
    if (rpage == 10'h000)
      e = {3'b010, 16'h0000};
    else if (!ea[15] || rpage < 10'h200)
      e = {3'b101, 16'h0000};
    else
      e = {3'b100, exp_data(word_at({1'b0, rpage[7:0], ea[14:0]}), rpage[9:8] == 2'b11,
                            bm, ea[0])};
    aq.push_back(e);
    @(posedge clk);
    vis_req <= 1'b0;
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((aq.size() != 0 || fq.size() != 0) && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 20)
    begin
      mismatches++;
      $display("ERROR results expected 0 seen %0d", aq.size() + fq.size());
      stop_test();
    end
  endtask

  task automatic jump(input logic [22:0] t);
    @(posedge clk);
    fetch_jump <= 1'b1;
    fetch_target <= t;
    @(posedge clk);
    fetch_jump <= 1'b0;
  endtask

  task automatic fetch_run(input int n);
    @(posedge clk);
    fetch_req <= 1'b1;
    repeat (n) @(posedge clk);
    fetch_req <= 1'b0;
    drain();
  endtask

  // ************************************************************
  // expected fetches: pc model steps by two on each accepted fetch
  // ************************************************************
  always @(posedge clk)
  begin
    if (rst)
      exp_pc <= reset_target_vector_select ? pma_pkg::RST_VEC_AUX : pma_pkg::RST_VEC_PRIMARY;
    else if (fetch_jump)
      exp_pc <= {fetch_target[22:1], 1'b0};
    else if (fetch_req && fetch_ready === 1'b1)
    begin
      fq.push_back(word_at({1'b0, exp_pc}));
      exp_pc <= exp_pc + 23'h000002;
    end
  end

  // result watchers take the oldest note whenever an answer appears
  always @(posedge clk)
  begin
    if (!rst && rd_ans.valid === 1'b1)
    begin
      cur = aq.pop_front();
      if (cur.valid)
        `CHK("rd_ans", cur[17:0], rd_ans[17:0])
      else
        `CHK("trap", 1'b1, rd_ans.trap)
    end
    // pop once: the check macro names its expected value twice
    if (!rst && fetch_valid === 1'b1)
    begin
      fexp = fq.pop_front();
      `CHK("fetch_word", fexp, fetch_word)
    end
  end

  // a hang anywhere ends the run as a failure
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    stop_test();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    reg_rd(pma_pkg::OFS_TABLE_PAGE, 32'h0, pma_pkg::RESP_OKAY);
    reg_rd(pma_pkg::OFS_DATA_READ_PAGE, 32'h1, pma_pkg::RESP_OKAY);
    reg_wr(4'hC, 32'hFFFFFFFF, 4'hF);
    reg_rd(4'hC, 32'h0, pma_pkg::RESP_SLVERR);
    reg_wr(pma_pkg::OFS_TABLE_PAGE, 32'hFFFFFFFF, 4'hF);
    reg_rd(pma_pkg::OFS_TABLE_PAGE, 32'hFF, pma_pkg::RESP_OKAY);
    reg_wr(pma_pkg::OFS_DATA_READ_PAGE, 32'hFFFFFFFF, 4'hF);
    reg_rd(pma_pkg::OFS_DATA_READ_PAGE, 32'h3FF, pma_pkg::RESP_OKAY);
    reg_wr(pma_pkg::OFS_DATA_READ_PAGE, 32'h0, 4'h1);
    reg_rd(pma_pkg::OFS_DATA_READ_PAGE, 32'h300, pma_pkg::RESP_OKAY);
    // every table mode back to back, page ends first
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      reg_wr(pma_pkg::OFS_TABLE_PAGE, {24'h0, seed[7:0]}, 4'hF);
      for (int m = 0; m < 8; m++)
        tbl_rd(m[2], m[1], (i == 0 ? 16'hFFFE : i == 1 ? 16'h0000 : seed[23:8]) | m[0]);
      @(posedge clk);
      table_read_req <= 1'b0;
    end
    drain();
    // window reads across trap, data and program pages
    for (int i = 0; i < 7; i++)
    begin
      seed = lfsr(seed);
      reg_wr(pma_pkg::OFS_DATA_READ_PAGE, {22'h0, pl[i]}, 4'hF);
      vis_rd(1'b0, {1'b1, seed[14:0]});
      vis_rd(1'b1, {1'b1, seed[30:16]});
      if (pl[i] != 10'h000)
        vis_rd(1'b0, {1'b0, seed[14:0]});
    end
    drain();
    // page zero left the sticky trap flag set; pc still at the primary vector
    reg_rd(pma_pkg::OFS_STATUS, 32'h80000000, pma_pkg::RESP_OKAY);
    reg_wr(pma_pkg::OFS_STATUS, 32'h80000000, 4'h8);
    reg_rd(pma_pkg::OFS_STATUS, 32'h0, pma_pkg::RESP_OKAY);
    // fetch with a table read stealing a slot
    jump(23'h000123);
    @(negedge clk);
    `CHK("pc", 23'h000122, pc)
    fork
      fetch_run(10);
      begin
        repeat (4) @(posedge clk);
        tbl_rd(1'b0, 1'b0, 16'h1234);
        @(posedge clk);
        table_read_req <= 1'b0;
      end
    join
    `CHK("pc", exp_pc, pc)
    aux_flash_busy <= 1'b1;
    fetch_run(6);
    `CHK("pc", 23'h000122 + 23'h00001E, pc)
    aux_flash_busy <= 1'b0;
    user_flash_busy <= 1'b1;
    jump(23'h7FC011);
    fetch_run(6);
    `CHK("pc", 23'h7FC01C, pc)
    jump(23'h000100);
    fetch_run(4);
    `CHK("pc", 23'h000100, pc)
    user_flash_busy <= 1'b0;
    // second reset with the strap set picks the other vector
    reset_target_vector_select <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK("pc", pma_pkg::RST_VEC_AUX, pc)
    reg_rd(pma_pkg::OFS_DATA_READ_PAGE, 32'h1, pma_pkg::RESP_OKAY);
    fetch_run(3);
    `CHK("pc", pma_pkg::RST_VEC_AUX + 23'h000006, pc)
    stop_test();
  end
endmodule // tb
